// ===== core/opc_regs.svh
`ifndef OPC_REGS_SVH
`define OPC_REGS_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define OPC_A_MODE       8'h00
`define OPC_A_LEVEL      8'h04
`define OPC_A_CMD        8'h08
`define OPC_A_STAT       8'h0C
`define OPC_A_START      8'h10
`define OPC_A_STOP       8'h20
// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define OPC_CMD_RESTORE  0
`define OPC_CMD_RTCLR    1
`define OPC_LEVEL_DEF    2'h1
`define OPC_LEVEL_MAX    2'h2
`define OPC_DELAY_DEF    10'h000
`define OPC_DELAY_MAX    10'h3DE
`define OPC_SEL_ALL_ON   3'h4
`define OPC_SEL_ALL_OFF  3'h5
`define OPC_KEY_MODE     0
`define OPC_KEY_UP       1
`define OPC_KEY_DOWN     2
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define OPC_CLK_NS       8
`define OPC_TICK_NS      100000000
`define OPC_TICK_CYC     (`OPC_TICK_NS / `OPC_CLK_NS)
`define OPC_DEB_NS       10000000
`define OPC_DEB_CYC      (`OPC_DEB_NS / `OPC_CLK_NS)
`define OPC_BLINK_TICKS  3'h4
`endif

// ===== core/opc_pkg.sv
`default_nettype none
package opc_pkg;
   typedef enum logic [1:0] {
      MD_BOOT = 2'h0,
      MD_SET  = 2'h1,
      MD_RUN  = 2'h3,
      MD_TEST = 2'h2
   } opc_mode_t;
   typedef logic [9:0] opc_delay_t;
endpackage
`default_nettype wire

// ===== core/opc_key_if.sv
`default_nettype none
interface opc_key_if;
   logic [2:0] press;
   modport src (output press);
   modport snk (input press);
endinterface
`default_nettype wire

// ===== core/opc_key_filter.sv
`include "opc_regs.svh"
`default_nettype none
module opc_key_filter #(
   parameter int unsigned DEB_CYC = `OPC_DEB_CYC
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [2:0] keys_raw,
   opc_key_if.src          kif
);
   localparam int DW = $clog2(DEB_CYC + 1);
   logic [2:0]    s1_q, s2_q, stab_q, stab_d, prs_q, prs_d;
   logic [DW-1:0] cnt_q [3];
   logic [DW-1:0] cnt_d [3];

   // ------------------------------------------------------------
   // Debounce and press decode
   // ------------------------------------------------------------
   always_comb begin
      stab_d = stab_q;
      prs_d  = 3'h0;
      for (int k = 0; k < 3; k++) begin
         cnt_d[k] = '0;
         if (s2_q[k] != stab_q[k]) begin
            if (cnt_q[k] == DW'(DEB_CYC - 1)) begin
               stab_d[k] = s2_q[k];
               prs_d[k]  = s2_q[k];
            end else begin
               cnt_d[k] = cnt_q[k] + DW'(1);
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q   <= 3'h0;
         s2_q   <= 3'h0;
         stab_q <= 3'h0;
         prs_q  <= 3'h0;
         for (int k = 0; k < 3; k++) begin
            cnt_q[k] <= '0;
         end
      end else begin
         s1_q   <= keys_raw;
         s2_q   <= s1_q;
         stab_q <= stab_d;
         prs_q  <= prs_d;
         cnt_q  <= cnt_d;
      end
   end

   assign kif.press = prs_q;
endmodule
`default_nettype wire

// ===== core/opc_mode_ctrl.sv
// Register access over APB and the register addresses were chosen for this implementation.
`include "opc_regs.svh"
`default_nettype none
module opc_mode_ctrl #(
   parameter int unsigned TICK_CYC = `OPC_TICK_CYC,
   parameter int unsigned DEB_CYC  = `OPC_DEB_CYC
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [2:0]        keys_raw,
   input  wire logic [3:0]        trip_cut,
   input  wire logic [3:0]        limit_cut,
   input  wire logic              nv_first_pwr,
   input  wire logic [1:0]        nv_last_mode,
   input  wire logic [1:0]        nv_level,
   output opc_pkg::opc_mode_t     mode,
   output logic      [1:0]        nv_level_out,
   output logic                   nv_first_done,
   output logic      [3:0]        branch_on,
   output logic      [3:0]        led_green,
   output logic      [3:0]        led_red,
   output logic                   peak_clr,
   output logic      [1:0]        peak_sel,
   output logic                   run_time_clr
);
   import opc_pkg::*;
   localparam int TW = $clog2(TICK_CYC + 1);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   opc_key_if kif ();
   opc_mode_t     mode_q, mode_d;
   logic [1:0]    lvl_q, lvl_d, boot_q, boot_d;
   logic          first_q, first_d;
   logic [2:0]    sync1_q, sync2_q;
   logic [3:0]    tr1_q, tr2_q, lc1_q, lc2_q;
   logic [1:0]    nl1_q, nl2_q, nm1_q, nm2_q;
   opc_delay_t    sdly_q [4];
   opc_delay_t    sdly_d [4];
   opc_delay_t    pdly_q [4];
   opc_delay_t    pdly_d [4];
   opc_delay_t    cnt_q  [4];
   opc_delay_t    cnt_d  [4];
   logic [3:0]    on_q, on_d, want_q, want_d, pend_q, pend_d;
   logic [3:0]    bon_q, bon_d, grn_q, grn_d, red_q, red_d;
   logic [2:0]    sel_q, sel_d, blk_q, blk_d;
   logic          blink_q, blink_d, tick_q, tick_d;
   logic [TW-1:0] tcnt_q, tcnt_d;
   logic [31:0]   rdata_q, rdata_d;
   logic          rdy_q, rdy_d, err_q, err_d;
   logic          pclr_q, pclr_d, rtc_q, rtc_d;
   logic [1:0]    psel_q, psel_d;
   logic          acc, wr, dhit_s, dhit_p, rcmd;
   logic [1:0]    didx;

   opc_key_filter #(.DEB_CYC(DEB_CYC)) u_keys (
      .pclk     (pclk),
      .presetn  (presetn),
      .keys_raw (keys_raw),
      .kif      (kif)
   );

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic dly_hit(input logic [7:0] a,
                                    input logic [7:0] base);
      return (a[7:4] == base[7:4]) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [1:0] next_sel(input logic [2:0] s,
                                           input logic       up,
                                           input logic [2:0] top);
      logic [2:0] n;
      n = s;
      if (up) begin
         n = (s == top) ? 3'h0 : s + 3'h1;
      end else begin
         n = (s == 3'h0) ? top : s - 3'h1;
      end
      return n[1:0];
   endfunction

   assign acc    = psel && penable && rdy_q;
   assign wr     = acc && pwrite;
   assign dhit_s = dly_hit(paddr, `OPC_A_START);
   assign dhit_p = dly_hit(paddr, `OPC_A_STOP);
   assign didx   = paddr[3:2];

   // ------------------------------------------------------------
   // Time base and blink
   // ------------------------------------------------------------
   always_comb begin
      tick_d  = 1'b0;
      tcnt_d  = tcnt_q + TW'(1);
      blk_d   = blk_q;
      blink_d = blink_q;
      if (tcnt_q == TW'(TICK_CYC - 1)) begin
         tcnt_d = '0;
         tick_d = 1'b1;
      end
      if (tick_q) begin
         blk_d = blk_q + 3'h1;
         if (blk_q == `OPC_BLINK_TICKS) begin
            blk_d   = 3'h0;
            blink_d = !blink_q;
         end
      end
   end

   // ------------------------------------------------------------
   // APB slave, modes, levels and parameters
   // ------------------------------------------------------------
   always_comb begin
      mode_d  = mode_q;
      lvl_d   = lvl_q;
      boot_d  = boot_q;
      first_d = first_q;
      sdly_d  = sdly_q;
      pdly_d  = pdly_q;
      rdy_d   = psel && penable && !rdy_q;
      rdata_d = rdata_q;
      err_d   = 1'b0;
      rtc_d   = 1'b0;
      rcmd    = 1'b0;
      if (psel && penable && !rdy_q) begin
         rdata_d = 32'h0;
         if (paddr == `OPC_A_MODE) begin
            rdata_d[1:0] = mode_q;
         end else if (paddr == `OPC_A_LEVEL) begin
            rdata_d[1:0] = lvl_q;
         end else if (paddr == `OPC_A_STAT) begin
            rdata_d[15:0] = {pend_q, want_q, on_q, bon_q};
         end else if (dhit_s) begin
            rdata_d[9:0] = sdly_q[didx];
         end else if (dhit_p) begin
            rdata_d[9:0] = pdly_q[didx];
         end else if (paddr != `OPC_A_CMD) begin
            err_d = 1'b1;
         end
         if (pwrite) begin
            if (paddr == `OPC_A_MODE) begin
               err_d = (pwdata[1:0] == MD_BOOT) ||
                       (pwdata[1:0] == MD_TEST &&
                        lvl_q == `OPC_LEVEL_MAX);
            end else if (paddr == `OPC_A_LEVEL) begin
               err_d = pwdata[1:0] > `OPC_LEVEL_MAX;
            end else if (paddr == `OPC_A_CMD) begin
               err_d = (pwdata[`OPC_CMD_RESTORE] &&
                        lvl_q != 2'h0) ||
                       (pwdata[`OPC_CMD_RTCLR] &&
                        (lvl_q == `OPC_LEVEL_MAX || mode_q != MD_SET));
            end else if (dhit_s || dhit_p) begin
               err_d = mode_q != MD_SET ||
                       lvl_q == `OPC_LEVEL_MAX ||
                       (dhit_p && lvl_q != 2'h0) ||
                       pwdata[9:0] > `OPC_DELAY_MAX;
            end
         end
      end
      unique case (mode_q)
         MD_BOOT: begin
            boot_d = boot_q + 2'h1;
            if (boot_q == 2'h3) begin
               first_d = 1'b1;
               if (nl2_q <= `OPC_LEVEL_MAX) begin
                  lvl_d = nl2_q;
               end
               mode_d = nm2_q[0] ? MD_RUN : MD_SET;
               if (sync2_q[0]) begin
                  mode_d = MD_SET;
                  lvl_d  = `OPC_LEVEL_DEF;
               end
            end
         end
         MD_SET, MD_RUN, MD_TEST: begin
            if (wr && !err_q && !err_d) begin
               if (paddr == `OPC_A_MODE) begin
                  mode_d = opc_mode_t'(pwdata[1:0]);
               end else if (paddr == `OPC_A_LEVEL) begin
                  lvl_d = pwdata[1:0];
               end else if (dhit_s) begin
                  sdly_d[didx] = pwdata[9:0];
               end else if (dhit_p) begin
                  pdly_d[didx] = pwdata[9:0];
               end else if (paddr == `OPC_A_CMD) begin
                  rtc_d = pwdata[`OPC_CMD_RTCLR];
                  if (pwdata[`OPC_CMD_RESTORE]) begin
                     mode_d = MD_SET;
                     rcmd   = 1'b1;
                     lvl_d  = `OPC_LEVEL_DEF;
                     for (int b = 0; b < 4; b++) begin
                        sdly_d[b] = `OPC_DELAY_DEF;
                        pdly_d[b] = `OPC_DELAY_DEF;
                     end
                  end
               end
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // Keys, branch sequencing and indicators
   // ------------------------------------------------------------
   always_comb begin
      on_d   = on_q;
      want_d = want_q;
      pend_d = pend_q;
      cnt_d  = cnt_q;
      sel_d  = sel_q;
      pclr_d = 1'b0;
      psel_d = psel_q;
      if (mode_q == MD_BOOT && mode_d == MD_RUN) begin
         want_d = 4'hF;
      end
      if (mode_q != MD_TEST && mode_d == MD_TEST) begin
         on_d   = 4'h0;
         want_d = 4'h0;
         pend_d = 4'h0;
         sel_d  = 3'h0;
      end
      if (rcmd) begin
         on_d   = 4'h0;
         want_d = 4'h0;
         pend_d = 4'h0;
      end
      if (mode_q == MD_TEST && mode_d == MD_TEST) begin
         if (kif.press[`OPC_KEY_UP] || kif.press[`OPC_KEY_DOWN]) begin
            sel_d = {1'b0, next_sel(sel_q, kif.press[`OPC_KEY_UP],
                                    `OPC_SEL_ALL_OFF)};
            if (kif.press[`OPC_KEY_UP] && sel_q == 3'h3) begin
               sel_d = `OPC_SEL_ALL_ON;
            end else if (kif.press[`OPC_KEY_UP] && sel_q == 3'h4) begin
               sel_d = `OPC_SEL_ALL_OFF;
            end else if (!kif.press[`OPC_KEY_UP] && sel_q == 3'h0) begin
               sel_d = `OPC_SEL_ALL_OFF;
            end else if (!kif.press[`OPC_KEY_UP] && sel_q == 3'h5) begin
               sel_d = `OPC_SEL_ALL_ON;
            end
         end
         if (kif.press[`OPC_KEY_MODE]) begin
            if (sel_q < `OPC_SEL_ALL_ON) begin
               on_d[sel_q[1:0]]   = !on_q[sel_q[1:0]];
               want_d[sel_q[1:0]] = !on_q[sel_q[1:0]];
               pend_d[sel_q[1:0]] = 1'b0;
            end else begin
               want_d = (sel_q == `OPC_SEL_ALL_ON) ? 4'hF : 4'h0;
            end
         end
      end
      if (mode_q == MD_RUN) begin
         if (kif.press[`OPC_KEY_UP] || kif.press[`OPC_KEY_DOWN]) begin
            psel_d = next_sel({1'b0, psel_q}, kif.press[`OPC_KEY_UP], 3'h3);
         end
         pclr_d = kif.press[`OPC_KEY_MODE];
      end
      // Sequencing runs in every mode, so setting mode keeps supplying
      for (int b = 0; b < 4; b++) begin
         if (want_d[b] != on_d[b] && !pend_d[b]) begin
            pend_d[b] = 1'b1;
            cnt_d[b]  = want_d[b] ? sdly_q[b] : pdly_q[b];
         end else if (want_d[b] == on_d[b]) begin
            pend_d[b] = 1'b0;
         end else if (cnt_q[b] == 10'h0) begin
            on_d[b]   = want_d[b];
            pend_d[b] = 1'b0;
         end else if (tick_q) begin
            cnt_d[b] = cnt_q[b] - 10'h1;
         end
      end
      // Entering run from setting or test keeps the branch state
      if (mode_q != MD_BOOT && mode_q != MD_RUN && mode_d == MD_RUN) begin
         want_d = on_d;
         pend_d = 4'h0;
      end
   end

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         bon_d[b] = on_q[b] && !tr2_q[b] && !lc2_q[b];
         grn_d[b] = 1'b0;
         red_d[b] = 1'b0;
         if (tr2_q[b]) begin
            red_d[b] = 1'b1;
         end else if (lc2_q[b]) begin
            red_d[b] = blink_q;
         end else if (on_q[b]) begin
            grn_d[b] = 1'b1;
         end else if (pend_q[b] && want_q[b]) begin
            grn_d[b] = blink_q;
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q  <= MD_BOOT;
         lvl_q   <= `OPC_LEVEL_DEF;
         boot_q  <= 2'h0;
         first_q <= 1'b0;
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         {tr1_q, tr2_q, lc1_q, lc2_q} <= 16'h0000;
         {nl1_q, nl2_q, nm1_q, nm2_q} <= 8'h00;
         for (int b = 0; b < 4; b++) begin
            sdly_q[b] <= `OPC_DELAY_DEF;
            pdly_q[b] <= `OPC_DELAY_DEF;
            cnt_q[b]  <= 10'h000;
         end
         {on_q, want_q, pend_q} <= 12'h000;
         {bon_q, grn_q, red_q}  <= 12'h000;
         sel_q   <= 3'h0;
         blk_q   <= 3'h0;
         blink_q <= 1'b0;
         tick_q  <= 1'b0;
         tcnt_q  <= '0;
         rdata_q <= 32'h0;
         rdy_q   <= 1'b0;
         err_q   <= 1'b0;
         pclr_q  <= 1'b0;
         rtc_q   <= 1'b0;
         psel_q  <= 2'h0;
      end else begin
         mode_q  <= mode_d;
         lvl_q   <= lvl_d;
         boot_q  <= boot_d;
         first_q <= first_d;
         sync1_q <= {2'h0, nv_first_pwr};
         sync2_q <= sync1_q;
         tr1_q   <= trip_cut;
         tr2_q   <= tr1_q;
         lc1_q   <= limit_cut;
         lc2_q   <= lc1_q;
         nl1_q   <= nv_level;
         nl2_q   <= nl1_q;
         nm1_q   <= nv_last_mode;
         nm2_q   <= nm1_q;
         sdly_q  <= sdly_d;
         pdly_q  <= pdly_d;
         cnt_q   <= cnt_d;
         on_q    <= on_d;
         want_q  <= want_d;
         pend_q  <= pend_d;
         bon_q   <= bon_d;
         grn_q   <= grn_d;
         red_q   <= red_d;
         sel_q   <= sel_d;
         blk_q   <= blk_d;
         blink_q <= blink_d;
         tick_q  <= tick_d;
         tcnt_q  <= tcnt_d;
         rdata_q <= rdata_d;
         rdy_q   <= rdy_d;
         err_q   <= rdy_d ? err_d : 1'b0;
         pclr_q  <= pclr_d;
         rtc_q   <= rtc_d;
         psel_q  <= psel_d;
      end
   end

   assign prdata        = rdata_q;
   assign pready        = rdy_q;
   assign pslverr       = err_q;
   assign mode          = mode_q;
   assign nv_level_out  = lvl_q;
   assign nv_first_done = first_q;
   assign branch_on     = bon_q;
   assign led_green     = grn_q;
   assign led_red       = red_q;
   assign peak_clr      = pclr_q;
   assign peak_sel      = psel_q;
   assign run_time_clr  = rtc_q;
endmodule
`default_nettype wire

// ===== verif/opc_mode_ctrl_asserts.sv
`include "opc_regs.svh"
`default_nettype none
module opc_mode_ctrl_asserts (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic               pwrite,
   input wire logic [7:0]         paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [3:0]         trip_cut,
   input wire logic               nv_first_pwr,
   input wire logic [1:0]         nv_last_mode,
   input wire opc_pkg::opc_mode_t mode,
   input wire logic [1:0]         nv_level_out,
   input wire logic [3:0]         branch_on,
   input wire logic               peak_clr,
   input wire logic               run_time_clr
);
   timeunit 1ns;
   timeprecision 1ps;
   import opc_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ------------------------------------------------------------
   // Sequences
   // ------------------------------------------------------------
   sequence s_setup; psel && !penable; endsequence
   sequence s_wait; psel && penable && !pready; endsequence
   sequence s_boot_end; $past(mode) == MD_BOOT && mode != MD_BOOT; endsequence
   sequence s_to_test; mode == MD_TEST && $past(mode) != MD_TEST; endsequence
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_ready_wait: assert property (s_setup ##1 s_wait |=> pready)
      else $error("pready not in second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_boot_hold: assert property ($rose(presetn) |-> (mode == MD_BOOT) [*3])
      else $error("boot left too early");
   a_first_set: assert property (s_boot_end ##0 nv_first_pwr |-> mode == MD_SET)
      else $error("first power-up not in setting mode");
   a_restart_run: assert property (s_boot_end ##0 !nv_first_pwr
      && nv_last_mode[0] |-> mode == MD_RUN)
      else $error("restart not in run mode");
   a_test_level: assert property (s_to_test |-> $past(nv_level_out) != 2'h2)
      else $error("test mode entered at level 2");
   a_test_cut: assert property (s_to_test |=> branch_on == 4'h0)
      else $error("branch on after test entry");
   a_restore_cut: assert property (psel && penable && pready && pwrite
      && !pslverr && paddr == `OPC_A_CMD && pwdata[`OPC_CMD_RESTORE]
      |=> ##1 branch_on == 4'h0)
      else $error("branch on after restore");
   a_fault_gate: assert property ($stable(trip_cut) [*5]
      |-> (branch_on & trip_cut) == 4'h0)
      else $error("branch on during fault cut");
   a_peak_run: assert property (peak_clr |-> mode == MD_RUN ##1 !peak_clr)
      else $error("peak clear outside run or too long");
   a_rtclr_set: assert property (run_time_clr
      |-> mode == MD_SET ##1 !run_time_clr)
      else $error("run time clear outside setting or too long");
endmodule
bind opc_mode_ctrl opc_mode_ctrl_asserts u_chk (.pclk, .presetn, .psel,
   .penable, .pready, .pslverr, .pwrite, .paddr, .pwdata, .trip_cut,
   .nv_first_pwr, .nv_last_mode, .mode,
   .nv_level_out, .branch_on, .peak_clr, .run_time_clr);
`default_nettype wire

// ===== verif/opc_panel_model.sv
`default_nettype none
module opc_panel_model (
   input  wire logic       pclk,
   output var  logic [2:0] keys_raw
);
   timeunit 1ns;
   timeprecision 1ps;
   initial keys_raw = 3'h0;
   // Hold past the debounce window, release before next press
   task automatic press(input int k);
      repeat (12) @(posedge pclk);
      keys_raw[k] <= 1'b1;
      repeat (12) @(posedge pclk);
      keys_raw[k] <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== verif/opc_mode_ctrl_tb.sv
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module opc_mode_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import opc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0]  keys_raw;
   logic [3:0]  trip_cut, limit_cut, branch_on, led_green, led_red;
   logic [1:0]  nv_last_mode, nv_level, nv_level_out, peak_sel;
   logic        nv_first_pwr, nv_first_done, peak_clr, run_time_clr, r1;
   opc_mode_t   mode;
   int          md, lv, dl[8], checks, n_errors, pcnt, rcnt, cyc, tb, lb;
   opc_mode_ctrl #(.TICK_CYC(20), .DEB_CYC(4)) DUT (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .keys_raw, .trip_cut, .limit_cut, .nv_first_pwr, .nv_last_mode,
      .nv_level, .mode, .nv_level_out, .nv_first_done, .branch_on,
      .led_green, .led_red, .peak_clr, .peak_sel, .run_time_clr);
   opc_panel_model u_pnl (.pclk, .keys_raw);
   // ------------------------------------------------------------
   // Reference model and bus tasks
   // ------------------------------------------------------------
   function automatic int ix(logic [7:0] a);
      return (a < 8'h10 || a > 8'h2C) ? -1 : (a - 8'h10) / 4;
   endfunction
   function automatic bit bad(logic [7:0] a, int d);
      if (ix(a) >= 0) return md != 1 || lv == 2 || d > 990 || (a > 8'h1C && lv != 0);
      case (a)
         8'h00: return d == 0 || (d == 2 && lv == 2);
         8'h04: return d > 2;
         8'h08: return d == 1 ? lv != 0 : (lv == 2 || md != 1);
         default: return 1;
      endcase
   endfunction
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input int d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= 32'(d);
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input int d);
      logic [31:0] r;
      logic e;
      bit x;
      x = bad(a, d);
      apb(1'b1, a, d, r, e);
      `CHK("wr_err", x, e)
      if (!x && a == 8'h00) md = d;
      if (!x && a == 8'h04) lv = d;
      if (!x && ix(a) >= 0) dl[ix(a)] = d;
      if (!x && a == 8'h08 && d == 1) begin
         md = 1;
         lv = 1;
         dl = '{default: 0};
      end
   endtask
   task automatic rd(input logic [7:0] a);
      logic [31:0] r;
      logic e;
      int x;
      x = (a == 0) ? md : (a == 4) ? lv : (ix(a) >= 0) ? dl[ix(a)] : 0;
      apb(1'b0, a, 0, r, e);
      `CHK("rd_err", a > 8'h2C, e)
      if (a <= 8'h2C) `CHK("rd_data", x, r)
   endtask
   task automatic boot(input int m);
      int n;
      n = 0;
      while (mode === MD_BOOT && n < 20) begin
         @(posedge pclk);
         n++;
      end
      idle(0);
      md = m;
      lv = nv_first_pwr ? 1 : nv_level;
      `CHK("mode", m, mode)
      `CHK("level", lv, nv_level_out)
      `CHK("first_done", 1, nv_first_done)
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Clock, pulse counters and timeout
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (peak_clr === 1'b1) pcnt <= pcnt + 1;
      if (run_time_clr === 1'b1) rcnt <= rcnt + 1;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {trip_cut, limit_cut, nv_last_mode} = '0;
      nv_first_pwr = 1'b1;
      nv_level = 2'h2;
      presetn = 1'b0;
      void'($urandom(83764));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      boot(1);
      rd(8'h04);
      for (int i = 0; i < 4; i++) begin
         wr(8'h10 + 8'(4 * i), int'($urandom % 991));
         rd(8'h10 + 8'(4 * i));
      end
      wr(8'h10, 991);
      wr(8'h20, 5);
      wr(8'h08, 1);
      wr(8'h04, 3);
      wr(8'h30 + 8'(4 * ($urandom % 52)), 1);
      rd(8'h30 + 8'(4 * ($urandom % 52)));
      wr(8'h04, 2);
      wr(8'h00, 2);
      wr(8'h14, 9);
      wr(8'h08, 2);
      wr(8'h04, 0);
      for (int i = 0; i < 3; i++) wr(8'h10 + 8'(4 * i), 0);
      wr(8'h1C, 40);
      wr(8'h20, 0);
      wr(8'h00, 2);
      idle(2);
      `CHK("on", 4'h0, branch_on)
      repeat (4) u_pnl.press(1);
      u_pnl.press(0);
      idle(0);
      `CHK("on", 4'h7, branch_on)
      idle(900);
      `CHK("on", 4'hF, branch_on)
      `CHK("green", 4'hF, led_green)
      tb = int'($urandom % 4);
      lb = int'((tb + 1 + $urandom % 3) % 4);
      @(posedge pclk);
      trip_cut <= 4'(1 << tb);
      idle(10);
      `CHK("on", 4'hF ^ 4'(1 << tb), branch_on)
      `CHK("red", 4'(1 << tb), led_red)
      @(posedge pclk);
      trip_cut <= 4'h0;
      limit_cut <= 4'(1 << lb);
      idle(10);
      r1 = led_red[lb];
      idle(100);
      `CHK("blink", 1'b1, r1 ^ led_red[lb])
      `CHK("on", 4'hF ^ 4'(1 << lb), branch_on)
      @(posedge pclk);
      limit_cut <= 4'h0;
      u_pnl.press(1);
      u_pnl.press(0);
      idle(60);
      `CHK("on", 4'h0, branch_on)
      `CHK("dark", 4'h0, led_green | led_red)
      u_pnl.press(1);
      u_pnl.press(0);
      idle(0);
      `CHK("on", 4'h1, branch_on)
      repeat (4) u_pnl.press(1);
      u_pnl.press(0);
      idle(900);
      wr(8'h00, 3);
      idle(2);
      `CHK("on", 4'hF, branch_on)
      u_pnl.press(0);
      u_pnl.press(1);
      idle(0);
      `CHK("peak", 1, pcnt)
      `CHK("sel", 2'h1, peak_sel)
      wr(8'h10, 3);
      wr(8'h08, 2);
      wr(8'h00, 1);
      idle(2);
      `CHK("on", 4'hF, branch_on)
      wr(8'h08, 2);
      idle(2);
      `CHK("rtclr", 1, rcnt)
      wr(8'h08, 1);
      idle(2);
      `CHK("on", 4'h0, branch_on)
      rd(8'h00);
      rd(8'h04);
      for (int i = 0; i < 8; i++) rd(8'h10 + 8'(4 * i));
      @(posedge pclk);
      presetn <= 1'b0;
      nv_first_pwr <= 1'b0;
      nv_last_mode <= 2'($urandom) | 2'h1;
      nv_level <= 2'($urandom % 3);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      boot(3);
      idle(80);
      `CHK("on", 4'hF, branch_on)
      rd(8'h04);
      conclude();
   end
endmodule
`default_nettype wire
